// ---- design/epw_pkg.sv ----
// Constants, field layouts and types shared by the event and pulse width counter
package epw_pkg;

  // ==========================================================================
  // Counter geometry
  localparam int            CNT_W        = 18;
  localparam logic [17:0]   CNT_MAX      = 18'h3FFFF;
  localparam logic [17:0]   CNT_ZERO     = 18'h00000;
  localparam int            CMP_LOW_BITS = 11;     // Compare bits ignored in slow undivided case
  localparam int            DIV_W        = 11;     // Width of the free-running divider

  // ==========================================================================
  // Register byte offsets
  localparam logic [4:0]    OFF_CTRL1    = 5'h00;  // counter_ctrl_one
  localparam logic [4:0]    OFF_CTRL2    = 5'h04;  // counter_ctrl_two
  localparam logic [4:0]    OFF_COMPARE  = 5'h08;  // compare_capture_reg
  localparam logic [4:0]    OFF_COUNT    = 5'h0C;  // Live count, read only
  localparam logic [4:0]    OFF_STATUS   = 5'h10;  // counter_status_reg
  localparam logic [4:0]    OFF_IRQSTAT  = 5'h14;  // Sticky events, cleared by read
  localparam logic [4:0]    OFF_IRQMASK  = 5'h18;  // Event mask

  // ==========================================================================
  // Field positions
  localparam int            SS_LSB       = 0;      // start_stop_ctrl, 2 bits
  localparam int            CLR_BIT      = 2;      // counter_clear_cmd, self clearing
  localparam int            SRC_LSB      = 4;      // count_source_sel, 3 bits
  localparam int            MODE_BIT     = 8;      // 0 event counter, 1 pulse width
  localparam int            EDGE_BIT     = 0;      // window_irq_edge_sel
  localparam int            SLOW_BIT     = 1;      // Slow mode flag
  localparam int            OVF_BIT      = 0;      // overflow_flag
  localparam int            MON_BIT      = 1;      // window_status_monitor
  localparam int            IRQ_MATCH    = 0;
  localparam int            IRQ_WIN      = 1;
  localparam int            IRQ_CMD      = 2;
  localparam int            IRQ_OVF      = 3;
  localparam int            IRQ_W        = 4;

  // ==========================================================================
  // Codes and reset values
  localparam logic [1:0]    SS_STOP      = 2'h0;
  localparam logic [1:0]    SS_START     = 2'h2;
  localparam logic [2:0]    SRC_DIV11    = 3'h0;   // Clock divided by 2^11
  localparam logic [2:0]    SRC_DIV7     = 3'h1;   // Clock divided by 2^7
  localparam logic [2:0]    SRC_DIV3     = 3'h2;   // Clock divided by 2^3
  localparam logic [2:0]    SRC_UNDIV    = 3'h3;   // Fastest internal source
  localparam logic [2:0]    SRC_EXT      = 3'h7;   // External event input
  localparam logic [2:0]    SRC_RST      = 3'h7;
  localparam logic [1:0]    SS_RST       = 2'h0;
  localparam logic [17:0]   CMP_RST      = 18'h3FFFF;
  localparam logic [3:0]    IRQ_RST      = 4'h0;
  localparam logic [DIV_W-1:0] DIV_RST   = 11'h000;

  typedef enum logic {
    MODE_EVENT = 1'b0,
    MODE_PULSE = 1'b1
  } mode_e;

endpackage

// ---- design/src_clk_if.sv ----
// Carries the count source selection and the internal source clock level
interface src_clk_if;
  logic [2:0] srcSel;
  logic       srcLevel;

  modport gen  (input srcSel, output srcLevel);
  modport user (output srcSel, input srcLevel);
endinterface

// ---- design/src_clk_gen.sv ----
// Free-running divider that produces the selected internal source clock level
module src_clk_gen (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic resetn,
  input  wire logic clkEn,
  // Source clock
  src_clk_if.gen    src
);

  // ==========================================================================
  // Divider
  logic [epw_pkg::DIV_W-1:0] div_q;
  logic [epw_pkg::DIV_W-1:0] div_d;
  logic                      level_q;
  logic                      level_d;

  // Picks the divider bit whose square wave matches the selected source
  function automatic logic tapBit(input logic [2:0] sel,
                                  input logic [epw_pkg::DIV_W-1:0] div);
    case (sel)
      epw_pkg::SRC_DIV11: tapBit = div[10];
      epw_pkg::SRC_DIV7:  tapBit = div[6];
      epw_pkg::SRC_DIV3:  tapBit = div[2];
      epw_pkg::SRC_UNDIV: tapBit = div[0];
      default:            tapBit = 1'b0;   // External source keeps the gate low
    endcase
  endfunction

  // Next divider count and tap level
  always_comb
  begin
    div_d   = div_q + 11'h001;
    level_d = tapBit(src.srcSel, div_d);
  end

  // Level is registered so the gate sees a glitch-free source
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      div_q   <= epw_pkg::DIV_RST;
      level_q <= 1'b0;
    end
    else if (clkEn)
    begin
      div_q   <= div_d;
      level_q <= level_d;
    end
  end

  assign src.srcLevel = level_q;

endmodule

// ---- design/event_pulse_counter.sv ----
// 18-bit event and pulse width counter with a classic Wishbone register slave
module event_pulse_counter (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        clkEn,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Pin and interrupt
  input  wire logic        eventInputPin,
  output logic             timerIrq
);

  // ==========================================================================
  // Declarations
  src_clk_if srcBus ();

  logic                    pinSync1_q, pinSync2_q, pinPrev_q, gatePrev_q;
  logic                    pinPrev_d, gatePrev_d;
  logic [1:0]              ctrlSs_q, ctrlSs_d;
  logic [2:0]              ctrlSrc_q, ctrlSrc_d;
  epw_pkg::mode_e          mode_q, mode_d;
  logic                    edgeSel_q, edgeSel_d;
  logic                    slowMode_q, slowMode_d;
  logic [17:0]             compare_q, compare_d;
  logic [17:0]             count_q, count_d;
  logic [17:0]             countNext;
  logic                    ovf_q, ovf_d;
  logic [3:0]              irqStat_q, irqStat_d;
  logic [3:0]              irqMask_q, irqMask_d;
  logic [3:0]              irqSet;
  logic                    ack_q, ack_d;
  logic [31:0]             datOut_q, datOut_d;
  logic                    wbStart, wbWrite, wbRead;
  logic [4:0]              wordAdr;
  logic [31:0]             wrWord;
  logic                    running, winFall, winRise, gate, gateFall;
  logic                    inc, cmpHit, wrap, clrCmd, stopIrq, startIrq;

  // Byte-lane merge of write data into an existing register image
  function automatic logic [31:0] wbMerge(input logic [31:0] old,
                                          input logic [31:0] din,
                                          input logic [3:0]  sel);
    for (int i = 0; i < 4; i++)
    begin
      wbMerge[i*8 +: 8] = sel[i] ? din[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  // Compare match, narrowed to the upper bits in the slow undivided case
  function automatic logic cmpMatch(input logic [17:0] cnt, input logic [17:0] cmp,
                                    input logic narrow);
    if (narrow)
      cmpMatch = cnt[17:epw_pkg::CMP_LOW_BITS] == cmp[17:epw_pkg::CMP_LOW_BITS];
    else
      cmpMatch = cnt == cmp;
  endfunction

  // ==========================================================================
  // Source clock divider
  src_clk_gen srcGen (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .clkEn   (clkEn),
    .src     (srcBus)
  );
  assign srcBus.srcSel = ctrlSrc_q;

  // ==========================================================================
  // Pin synchroniser; the edge logic reads only the second stage
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pinSync1_q <= 1'b0;
      pinSync2_q <= 1'b0;
    end
    else if (clkEn)
    begin
      pinSync1_q <= eventInputPin;
      pinSync2_q <= pinSync1_q;  // Two-cycle level minimum keeps every edge visible
    end
  end

  // ==========================================================================
  // Edge detection and count enables
  always_comb
  begin
    wordAdr    = {wb_adr_i[4:2], 2'b00};
    wbStart    = wb_cyc_i & wb_stb_i & ~ack_q;
    wbWrite    = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;
    wbRead     = wb_cyc_i & wb_stb_i & ~wb_we_i & ack_q;
    running    = ctrlSs_q == epw_pkg::SS_START;
    winFall    = pinPrev_q & ~pinSync2_q;
    winRise    = ~pinPrev_q & pinSync2_q;
    gate       = pinSync2_q & srcBus.srcLevel;
    // A window fall while the source is high is a gate fall too: one extra count
    gateFall   = gatePrev_q & ~gate;
    if (mode_q == epw_pkg::MODE_EVENT)
      inc = running & winFall;
    else
      inc = running & gateFall;
    countNext  = count_q + 18'h00001;
    wrap       = inc & (count_q == epw_pkg::CNT_MAX);
    cmpHit     = cmpMatch(countNext, compare_q,
                          slowMode_q & (ctrlSrc_q == epw_pkg::SRC_UNDIV));
    wrWord     = wbMerge(32'h0000_0000, wb_dat_i, wb_sel_i);
    clrCmd     = wbWrite & (wordAdr == epw_pkg::OFF_CTRL1) & wb_sel_i[0]
                 & wb_dat_i[epw_pkg::CLR_BIT];
    stopIrq    = wbWrite & (wordAdr == epw_pkg::OFF_CTRL1) & wb_sel_i[0]
                 & (mode_q == epw_pkg::MODE_PULSE) & pinSync2_q
                 & (wb_dat_i[1:0] == epw_pkg::SS_STOP);
    startIrq   = wbWrite & (wordAdr == epw_pkg::OFF_CTRL1) & wb_sel_i[0]
                 & (mode_q == epw_pkg::MODE_PULSE) & pinSync2_q & edgeSel_q
                 & (wb_dat_i[1:0] == epw_pkg::SS_START);
  end

  // ==========================================================================
  // Next state of counter, flags and registers
  always_comb
  begin
    pinPrev_d  = pinSync2_q;
    gatePrev_d = gate;
    ctrlSs_d   = ctrlSs_q;
    ctrlSrc_d  = ctrlSrc_q;
    mode_d     = mode_q;
    edgeSel_d  = edgeSel_q;
    slowMode_d = slowMode_q;
    compare_d  = compare_q;
    irqMask_d  = irqMask_q;
    count_d    = count_q;   // Holds while stopped so the next run resumes
    irqSet     = 4'h0;
    ack_d      = wbStart;
    datOut_d   = datOut_q;
    // Counting
    if (inc)
    begin
      count_d = countNext;
      if ((mode_q == epw_pkg::MODE_EVENT) && cmpHit)
      begin
        count_d                 = epw_pkg::CNT_ZERO;
        irqSet[epw_pkg::IRQ_MATCH] = 1'b1;
      end
    end
    irqSet[epw_pkg::IRQ_OVF] = wrap;
    // Window edges in pulse mode
    if (running && (mode_q == epw_pkg::MODE_PULSE))
      irqSet[epw_pkg::IRQ_WIN] = winFall | (winRise & edgeSel_q);
    irqSet[epw_pkg::IRQ_CMD] = stopIrq | startIrq;
    // Register writes take effect at the edge after the one that presents ack, while ack_q is high
    if (wbWrite)
    begin
      case (wordAdr)
        epw_pkg::OFF_CTRL1:
        begin
          if (wb_sel_i[0])
          begin
            ctrlSs_d  = wb_dat_i[epw_pkg::SS_LSB +: 2];
            ctrlSrc_d = wb_dat_i[epw_pkg::SRC_LSB +: 3];
          end
          if (wb_sel_i[1])
            mode_d = epw_pkg::mode_e'(wb_dat_i[epw_pkg::MODE_BIT]);
        end
        epw_pkg::OFF_CTRL2:
        begin
          if (wb_sel_i[0])
          begin
            edgeSel_d  = wb_dat_i[epw_pkg::EDGE_BIT];
            slowMode_d = wb_dat_i[epw_pkg::SLOW_BIT];
          end
        end
        epw_pkg::OFF_COMPARE:
          compare_d = 18'(wbMerge({14'h0000, compare_q}, wb_dat_i, wb_sel_i));
        epw_pkg::OFF_IRQMASK:
          irqMask_d = wrWord[3:0] | (irqMask_q & ~{4{wb_sel_i[0]}});
        default:
          irqMask_d = irqMask_q;   // Unmapped and read-only offsets ignore writes
      endcase
    end
    if (clrCmd)
      count_d = epw_pkg::CNT_ZERO;
    // Overflow: a wrap in the clearing cycle still sets the flag
    ovf_d = (ovf_q & ~clrCmd) | wrap;
    // Sticky events: only the bits handed out are cleared, so an event that
    // lands between data capture and ack is kept; a set in that cycle wins
    irqStat_d = irqSet | (irqStat_q
                & ~({4{wbRead && (wordAdr == epw_pkg::OFF_IRQSTAT)}} & datOut_q[3:0]));
    // Read data is captured as ack rises
    if (wbStart && !wb_we_i)
    begin
      case (wordAdr)
        epw_pkg::OFF_CTRL1:   datOut_d = {23'h000000, mode_q, 1'b0, ctrlSrc_q, 2'h0, ctrlSs_q};
        epw_pkg::OFF_CTRL2:   datOut_d = {30'h00000000, slowMode_q, edgeSel_q};
        epw_pkg::OFF_COMPARE: datOut_d = {14'h0000, compare_q};
        epw_pkg::OFF_COUNT:   datOut_d = {14'h0000, count_q};
        // Monitor bit is meaningless in pulse mode and reads zero there
        epw_pkg::OFF_STATUS:  datOut_d = {30'h00000000,
                                pinSync2_q & (mode_q == epw_pkg::MODE_EVENT), ovf_q};
        epw_pkg::OFF_IRQSTAT: datOut_d = {28'h0000000, irqStat_q};
        epw_pkg::OFF_IRQMASK: datOut_d = {28'h0000000, irqMask_q};
        default:              datOut_d = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // State registers, all frozen while clkEn is low
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pinPrev_q  <= 1'b0;
      gatePrev_q <= 1'b0;
      ctrlSs_q   <= epw_pkg::SS_RST;
      ctrlSrc_q  <= epw_pkg::SRC_RST;
      mode_q     <= epw_pkg::MODE_EVENT;
      edgeSel_q  <= 1'b0;
      slowMode_q <= 1'b0;
      compare_q  <= epw_pkg::CMP_RST;
      count_q    <= epw_pkg::CNT_ZERO;
      ovf_q      <= 1'b0;
      irqStat_q  <= epw_pkg::IRQ_RST;
      irqMask_q  <= epw_pkg::IRQ_RST;
      ack_q      <= 1'b0;
      datOut_q   <= 32'h0000_0000;
    end
    else if (clkEn)
    begin
      pinPrev_q  <= pinPrev_d;
      gatePrev_q <= gatePrev_d;
      ctrlSs_q   <= ctrlSs_d;
      ctrlSrc_q  <= ctrlSrc_d;
      mode_q     <= mode_d;
      edgeSel_q  <= edgeSel_d;
      slowMode_q <= slowMode_d;
      compare_q  <= compare_d;
      count_q    <= count_d;
      ovf_q      <= ovf_d;
      irqStat_q  <= irqStat_d;
      irqMask_q  <= irqMask_d;
      ack_q      <= ack_d;
      datOut_q   <= datOut_d;
    end
  end

  // ==========================================================================
  // Outputs
  assign wb_ack_o = ack_q;
  assign wb_dat_o = datOut_q;
  assign timerIrq = |(irqStat_q & irqMask_q);

  // ==========================================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  AST_EVENT_INC: assert property (clkEn && inc && mode_q == epw_pkg::MODE_EVENT
      && !cmpHit && !clrCmd |=> count_q == $past(countNext))
    else $error("event count did not advance by one");
  AST_MATCH_CLEAR: assert property (clkEn && inc && mode_q == epw_pkg::MODE_EVENT
      && cmpHit |=> count_q == 18'h00000 && irqStat_q[0])
    else $error("compare match did not clear and flag");
  AST_SLOW_NARROW: assert property (clkEn && inc && mode_q == epw_pkg::MODE_EVENT
      && slowMode_q && ctrlSrc_q == epw_pkg::SRC_UNDIV
      && countNext[17:11] == compare_q[17:11] |=> count_q == 18'h00000)
    else $error("narrow compare missed");
  AST_PULSE_INC: assert property (clkEn && running && mode_q == epw_pkg::MODE_PULSE
      && gateFall && !clrCmd |=> count_q == $past(countNext))
    else $error("gated fall did not count");
  AST_WIN_FALL: assert property (clkEn && running && mode_q == epw_pkg::MODE_PULSE
      && winFall |=> irqStat_q[1])
    else $error("window fall did not flag");
  AST_WIN_RISE_QUIET: assert property (clkEn && winRise && !edgeSel_q
      && !irqStat_q[1] |=> !irqStat_q[1])
    else $error("rise flagged with falling-only select");
  AST_HOLD_STOPPED: assert property (clkEn && !running && !clrCmd
      |=> $stable(count_q))
    else $error("count moved while stopped");
  AST_WRAP_OVF: assert property (clkEn && wrap |=> ovf_q && count_q == 18'h00000)
    else $error("wrap did not set overflow");
  AST_OVF_HOLD: assert property (clkEn && ovf_q && !clrCmd |=> ovf_q)
    else $error("overflow dropped without clear");
  AST_CLEAR_CMD: assert property (clkEn && clrCmd && !wrap
      |=> !ovf_q && count_q == 18'h00000)
    else $error("clear command ignored");
  AST_STOP_IRQ: assert property (clkEn && stopIrq |=> irqStat_q[2])
    else $error("stop with window high did not flag");
  AST_START_IRQ: assert property (clkEn && startIrq |=> irqStat_q[2])
    else $error("start with window high did not flag");
  AST_MON_PULSE: assert property (clkEn && wbStart && !wb_we_i
      && wordAdr == epw_pkg::OFF_STATUS && mode_q == epw_pkg::MODE_PULSE
      |=> !wb_dat_o[1])
    else $error("monitor bit visible in pulse mode");

endmodule

// ---- verification/pulse_source.sv ----
// Behavioural model of the pulse source that drives the event pin
module pulse_source (
  // Clock
  input  wire logic ref_clk,
  // Pin drive
  output logic      pinLevel
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Pin timing
  localparam int HALF = 8;  // Cycles per level; pulses() adds one low cycle per loop, so one period is 17 cycles
  initial pinLevel = 1'b0;

  // High is held HALF cycles and low HALF+1, well above two and at clock/17
  task automatic pulses(input int n);
    repeat (n)
    begin
      @(posedge ref_clk);
      pinLevel <= 1'b1;
      repeat (HALF) @(posedge ref_clk);
      pinLevel <= 1'b0;
      repeat (HALF) @(posedge ref_clk);
    end
  endtask

  // Window level change, then a settle time so the synchroniser catches up
  task automatic set_level(input logic v);
    @(posedge ref_clk);
    pinLevel <= v;
    repeat (HALF) @(posedge ref_clk);
  endtask
endmodule

// ---- verification/testbench.sv ----
// Self-checking bench for the event and pulse width counter
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Signals
  logic        ref_clk;
  logic        resetn;
  logic        clkEn;
  logic        wbCyc;
  logic        wbStb;
  logic        wbWe;
  logic [4:0]  wbAdr;
  logic [3:0]  wbSel;
  logic [31:0] wbDatW;
  logic [31:0] wbDatR;
  logic        wbAck;
  logic        eventInputPin;
  logic        timerIrq;
  logic [31:0] rd;
  logic [31:0] c1;
  int          n_mismatch;
  int          comparisons;

  // ==========================================================================
  // Design and pulse source
  event_pulse_counter dut (.ref_clk(ref_clk), .resetn(resetn), .clkEn(clkEn),
    .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
    .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck),
    .eventInputPin(eventInputPin), .timerIrq(timerIrq));
  pulse_source src (.ref_clk(ref_clk), .pinLevel(eventInputPin));

  // ==========================================================================
  // Shared tasks
  task automatic report_and_stop();
    if (n_mismatch == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("wrong value %s expected %0h seen %0h", what, e, g);
    end
  endtask

  // Window counts depend on the source phase, so a small band is accepted
  task automatic check_range(input string what, input int lo, input int hi,
                             input logic [31:0] g);
    comparisons++;
    if (!((g >= lo) === 1'b1 && (g <= hi) === 1'b1))
    begin
      n_mismatch++;
      $display("wrong value %s expected %0d..%0d seen %0d", what, lo, hi, g);
    end
  endtask

  // Classic cycle: request held until ack is sampled high, bounded wait
  task automatic wb_cycle(input logic we, input logic [4:0] adr, input logic [31:0] d,
                          input logic [3:0] sel, output logic [31:0] q);
    int n;
    @(posedge ref_clk);
    wbCyc  <= 1'b1;
    wbStb  <= 1'b1;
    wbWe   <= we;
    wbAdr  <= adr;
    wbSel  <= sel;
    wbDatW <= d;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (wbAck !== 1'b1 && n < 16);
    if (wbAck !== 1'b1)
    begin
      n_mismatch++;
      report_and_stop();
    end
    q = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe  <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] adr, input logic [31:0] d);
    logic [31:0] q;
    wb_cycle(1'b1, adr, d, 4'hF, q);
  endtask

  // Write with chosen byte lanes
  task automatic wrs(input logic [4:0] adr, input logic [31:0] d, input logic [3:0] sel);
    logic [31:0] q;
    wb_cycle(1'b1, adr, d, sel, q);
  endtask

  task automatic rdr(input logic [4:0] adr);
    wb_cycle(1'b0, adr, 32'h0, 4'hF, rd);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    check("irq", 32'h0, {31'h0, timerIrq});
    rdr(epw_pkg::OFF_COUNT);
    check("count", 32'h0, rd);
    rdr(epw_pkg::OFF_STATUS);
    check("status", 32'h0, rd);
    rdr(epw_pkg::OFF_COMPARE);
    check("compare", 32'h3FFFF, rd);
    // Only byte lane 0 may change
    wrs(epw_pkg::OFF_COMPARE, 32'h0001_2345, 4'h1);
    rdr(epw_pkg::OFF_COMPARE);
    check("compare lane", 32'h3FF45, rd);
    rdr(5'h1C);
    check("unmapped", 32'h0, rd);
    src.pulses(2);
    rdr(epw_pkg::OFF_COUNT);
    check("stopped count", 32'h0, rd);
  endtask

  task automatic t_event();
    wr(epw_pkg::OFF_IRQMASK, 32'hF);
    wr(epw_pkg::OFF_COMPARE, 32'h3);
    wr(epw_pkg::OFF_CTRL1, 32'h72);
    src.pulses(2);
    rdr(epw_pkg::OFF_COUNT);
    check("event count", 32'h2, rd);
    check("irq early", 32'h0, {31'h0, timerIrq});
    src.pulses(1);
    check("irq match", 32'h1, {31'h0, timerIrq});
    rdr(epw_pkg::OFF_COUNT);
    check("count cleared", 32'h0, rd);
    rdr(epw_pkg::OFF_IRQSTAT);
    check("match bit", 32'h1, rd);
    @(negedge ref_clk);
    check("irq after read", 32'h0, {31'h0, timerIrq});
    src.pulses(1);
    rdr(epw_pkg::OFF_COUNT);
    check("count resumes", 32'h1, rd);
    // Pulses while the clock enable is low must leave the count alone
    @(posedge ref_clk);
    clkEn <= 1'b0;
    src.pulses(2);
    clkEn <= 1'b1;
    rdr(epw_pkg::OFF_COUNT);
    check("frozen count", 32'h1, rd);
    wr(epw_pkg::OFF_CTRL1, 32'h76);
    rdr(epw_pkg::OFF_COUNT);
    check("clear cmd", 32'h0, rd);
    rdr(epw_pkg::OFF_STATUS);
    check("overflow", 32'h0, rd & 32'h1);
  endtask

  task automatic t_slow();
    wr(epw_pkg::OFF_CTRL2, 32'h2);
    wr(epw_pkg::OFF_COMPARE, 32'h5);
    wr(epw_pkg::OFF_CTRL1, 32'h36);
    rdr(epw_pkg::OFF_IRQSTAT);
    src.pulses(1);
    rdr(epw_pkg::OFF_COUNT);
    check("slow count", 32'h0, rd);
    rdr(epw_pkg::OFF_IRQSTAT);
    check("slow match", 32'h1, rd & 32'h1);
    wr(epw_pkg::OFF_CTRL2, 32'h0);
    wr(epw_pkg::OFF_CTRL1, 32'h36);
    src.pulses(1);
    rdr(epw_pkg::OFF_COUNT);
    check("full compare", 32'h1, rd);
  endtask

  task automatic t_pulse();
    wr(epw_pkg::OFF_CTRL1, 32'h136);
    rdr(epw_pkg::OFF_IRQSTAT);
    src.set_level(1'b1);
    rdr(epw_pkg::OFF_IRQSTAT);
    check("rise irq", 32'h0, rd & 32'h2);
    rdr(epw_pkg::OFF_STATUS);
    check("monitor", 32'h0, rd & 32'h2);
    src.set_level(1'b0);
    rdr(epw_pkg::OFF_COUNT);
    c1 = rd;
    check_range("width one", 6, 9, c1);
    rdr(epw_pkg::OFF_IRQSTAT);
    check("fall irq", 32'h2, rd & 32'h2);
    src.set_level(1'b1);
    repeat (32) @(posedge ref_clk);
    src.set_level(1'b0);
    rdr(epw_pkg::OFF_COUNT);
    check_range("width two", c1 + 19, c1 + 22, rd);
    // Count was read with the window low; now clear it as software must
    wr(epw_pkg::OFF_CTRL1, 32'h136);
    rdr(epw_pkg::OFF_COUNT);
    check("count after clear", 32'h0, rd);
  endtask

  task automatic t_stop_start();
    wr(epw_pkg::OFF_CTRL2, 32'h1);
    wr(epw_pkg::OFF_CTRL1, 32'h136);
    rdr(epw_pkg::OFF_IRQSTAT);
    src.set_level(1'b1);
    rdr(epw_pkg::OFF_IRQSTAT);
    check("both edge rise", 32'h2, rd & 32'h2);
    // Mask, stop, clear latch, unmask, as software must do here
    wr(epw_pkg::OFF_IRQMASK, 32'h0);
    wr(epw_pkg::OFF_CTRL1, 32'h130);
    @(negedge ref_clk);
    check("masked irq", 32'h0, {31'h0, timerIrq});
    rdr(epw_pkg::OFF_IRQSTAT);
    check("stop irq", 32'h4, rd & 32'h4);
    wr(epw_pkg::OFF_IRQMASK, 32'hF);
    @(negedge ref_clk);
    check("irq unmasked", 32'h0, {31'h0, timerIrq});
    wr(epw_pkg::OFF_CTRL1, 32'h132);
    @(negedge ref_clk);
    check("start irq line", 32'h1, {31'h0, timerIrq});
    rdr(epw_pkg::OFF_IRQSTAT);
    check("start irq", 32'h4, rd & 32'h4);
    src.set_level(1'b0);
  endtask

  // A reset in mid-run clears the irq line and returns the count, ctrl one and irq mask to their reset values
  task automatic t_reset2();
    rdr(epw_pkg::OFF_CTRL1);
    check("ctrl one", 32'h132, rd);
    check("irq before reset", 32'h1, {31'h0, timerIrq});
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    @(negedge ref_clk);
    check("irq after reset", 32'h0, {31'h0, timerIrq});
    rdr(epw_pkg::OFF_COUNT);
    check("count after reset", 32'h0, rd);
    rdr(epw_pkg::OFF_CTRL1);
    check("ctrl after reset", 32'h70, rd);
    rdr(epw_pkg::OFF_IRQMASK);
    check("mask after reset", 32'h0, rd);
  endtask

  // ==========================================================================
  // Clock and main sequence
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial
  begin
    resetn      = 1'b0;
    clkEn       = 1'b1;
    wbCyc       = 1'b0;
    wbStb       = 1'b0;
    wbWe        = 1'b0;
    wbAdr       = 5'h00;
    wbSel       = 4'h0;
    wbDatW      = 32'h0;
    n_mismatch  = 0;
    comparisons = 0;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    t_reset();
    t_event();
    t_slow();
    t_pulse();
    t_stop_start();
    t_reset2();
    report_and_stop();
  end
endmodule
